// >>> rtl/rtu_pkg.sv
// rtu_pkg.sv: types shared by the raster timing unit files.
// assumes: compiled before any rtl module of the unit.
package rtu_pkg;
  typedef logic [15:0] rtu_addr_t;
  typedef logic [9:0] rtu_line_t;
  // cursor delay in character clocks
  typedef enum logic [1:0] {
    RTU_SKEW_0 = 2'b00,
    RTU_SKEW_1 = 2'b01,
    RTU_SKEW_2 = 2'b10,
    RTU_SKEW_3 = 2'b11
  } rtu_skew_e;
endpackage

// >>> rtl/rtu_regfile.sv
// rtu_regfile.sv: byte register store with bit-masked writes, a flat
// view of every register and a registered read port.
// assumes: one clock, asynchronous active-low reset, masks from caller.
`timescale 1ns/1ps
`include "rtu_regs.svh"
module rtu_regfile import rtu_pkg::*; #(
  parameter int DEPTH = `RTU_NUM_REGS,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] wr_mask,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_q,
  output logic [DEPTH*8-1:0] flat
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic [7:0] rd_data_d;

  //////////////////////////////////////////////////////////////////////
  // masked writes keep reserved and protected bits untouched
  always_comb begin
    rd_data_d = 8'h00;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
      if (wr_en && wr_addr == AW'(i)) begin
        mem_d[i] = (mem_q[i] & ~wr_mask) | (wr_data & wr_mask);
      end
      if (rd_addr == AW'(i)) begin
        rd_data_d = mem_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `RTU_REG_RESET;
      end
      rd_data_q <= 8'h00;
    end else begin
      mem_q <= mem_d;
      rd_data_q <= rd_data_d; // unmapped index reads zero
    end
  end

  // flat view for the timing logic
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_flat
      assign flat[g*8 +: 8] = mem_q[g];
    end
  endgenerate
endmodule

// >>> rtl/rtu_regs.svh
// rtu_regs.svh: register indices, field positions, reset values and
// fixed counts of the raster timing unit.
// assumes: included by its bare name inside the design files.
`ifndef RTU_REGS_SVH
`define RTU_REGS_SVH

// register indices behind the data port
`define RTU_IDX_VTOTAL      5'h06
`define RTU_IDX_OVERFLOW    5'h07
`define RTU_IDX_MAX_SCAN    5'h09
`define RTU_IDX_CUR_FIRST   5'h0A
`define RTU_IDX_CUR_LAST    5'h0B
`define RTU_IDX_ORIGIN_HI   5'h0C
`define RTU_IDX_ORIGIN_LO   5'h0D
`define RTU_IDX_CURPOS_HI   5'h0E
`define RTU_IDX_CURPOS_LO   5'h0F
`define RTU_IDX_VSYNC_BEGIN 5'h10
`define RTU_IDX_VSYNC_END   5'h11
`define RTU_IDX_ACTIVE_END  5'h12
`define RTU_IDX_ROW_PITCH   5'h13
`define RTU_IDX_UNDERLINE   5'h14
`define RTU_IDX_VBLANK_BEG  5'h15
`define RTU_IDX_VBLANK_END  5'h16
`define RTU_IDX_MODE        5'h17
`define RTU_IDX_SPLIT_LINE  5'h18
`define RTU_IDX_LAST_PROT   5'h07
`define RTU_NUM_REGS        25

// overflow register bit positions
`define RTU_OVF_VTOTAL8     0
`define RTU_OVF_ACTEND8     1
`define RTU_OVF_VSYNC8      2
`define RTU_OVF_VBLANK8     3
`define RTU_OVF_SPLIT8      4
`define RTU_OVF_VTOTAL9     5
`define RTU_OVF_ACTEND9     6
`define RTU_OVF_VSYNC9      7

// field positions in scan/cursor/vsync-end/underline/vblank-end/mode registers
`define RTU_MSL_VBLANK9     5
`define RTU_MSL_SPLIT9      6
`define RTU_MSL_DOUBLE      7
`define RTU_CUR_OFF         5
`define RTU_CUR_SKEW_LO     5
`define RTU_VSE_CLEAR       4
`define RTU_VSE_DISABLE     5
`define RTU_VSE_FIVE_REF    6
`define RTU_VSE_PROTECT     7
`define RTU_UL_COUNT4       5
`define RTU_UL_DWORD        6
`define RTU_VBE_SHIFT2      6
`define RTU_MODE_SUB13      0
`define RTU_MODE_SUB14      1
`define RTU_MODE_VHALF      2
`define RTU_MODE_COUNT2     3
`define RTU_MODE_WRAP15     5
`define RTU_MODE_BYTE       6
`define RTU_MODE_RETRACE    7
`define RTU_OVF_PROT_MASK   8'h10

// writable-bit masks and reset values
`define RTU_MASK_CUR_FIRST  8'h3F
`define RTU_MASK_CUR_LAST   8'h7F
`define RTU_MASK_UNDERLINE  8'h7F
`define RTU_MASK_MODE       8'hEF
`define RTU_MASK_FULL       8'hFF
`define RTU_REG_RESET       8'h00

// refresh cycles per line
`define RTU_REFRESH_THREE   3'h3
`define RTU_REFRESH_FIVE    3'h5

`endif

// >>> rtl/rtu_timing.sv
// rtu_timing.sv: vertical, cursor and address side of the raster timing
// unit, with its index/data register port.
// assumes: clk is the character clock; the horizontal section supplies
// one-cycle line pulses, its retrace level and its display window.
`timescale 1ns/1ps
`include "rtu_regs.svh"
module rtu_timing import rtu_pkg::*; #(
  parameter int NREGS = `RTU_NUM_REGS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // index/data register port
  input wire logic port_wr,
  input wire logic port_sel,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  // horizontal section
  input wire logic hline_pulse,
  input wire logic hretrace_in,
  input wire logic hdisp_in,
  // monitor timing
  output logic hretrace_out,
  output logic vretrace_out,
  output logic vblank_out,
  output logic vdisp_out,
  output logic cursor_out,
  output logic underline_out,
  // memory fetch
  output logic [15:0] mem_addr,
  output logic [4:0] row_scan,
  output logic [2:0] refresh_cycles,
  // vertical retrace interrupt
  output logic vint_pending,
  output logic irq
);
  logic [NREGS*8-1:0] flat;
  logic [7:0] rf_rdata;
  logic [7:0] wr_mask;
  logic rf_we;

  //////////////////////////////////////////////////////////////////////
  // register access

  // register byte by index from the flat view
  function automatic logic [7:0] rg(input logic [NREGS*8-1:0] f,
                                    input logic [4:0] i);
    rg = f[i*8 +: 8];
  endfunction

  // writable bits of each index; reserved bits stay zero
  function automatic logic [7:0] res_mask(input logic [4:0] i);
    case (i)
      `RTU_IDX_CUR_FIRST: res_mask = `RTU_MASK_CUR_FIRST;
      `RTU_IDX_CUR_LAST: res_mask = `RTU_MASK_CUR_LAST;
      `RTU_IDX_UNDERLINE: res_mask = `RTU_MASK_UNDERLINE;
      `RTU_IDX_MODE: res_mask = `RTU_MASK_MODE;
      default: res_mask = `RTU_MASK_FULL;
    endcase
  endfunction

  logic [4:0] idx_q, idx_d;
  logic [7:0] rdata_q, rdata_d;
  logic prot;

  // direct flat bit: a bit-select of a function result is not portable
  assign prot = flat[`RTU_IDX_VSYNC_END * 8 + `RTU_VSE_PROTECT];

  // protection: 0-7 locked, split-line bit of overflow still open
  always_comb begin
    idx_d = idx_q;
    if (port_wr && !port_sel) begin
      idx_d = port_wdata[4:0];
    end
    rf_we = port_wr && port_sel && (idx_q < 5'(NREGS));
    wr_mask = res_mask(idx_q);
    if (prot && idx_q == `RTU_IDX_OVERFLOW) begin
      wr_mask = `RTU_OVF_PROT_MASK;
    end else if (prot && idx_q < `RTU_IDX_LAST_PROT) begin
      wr_mask = 8'h00;
    end
    rdata_d = port_sel ? rf_rdata : {3'h0, idx_q};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_q <= 5'h00;
      rdata_q <= 8'h00;
    end else begin
      idx_q <= idx_d;
      rdata_q <= rdata_d;
    end
  end
  assign port_rdata = rdata_q;

  rtu_regfile #(
    .DEPTH(NREGS),
    .AW(5)
  ) u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(rf_we),
    .wr_addr(idx_q),
    .wr_data(port_wdata),
    .wr_mask(wr_mask),
    .rd_addr(idx_q),
    .rd_data_q(rf_rdata),
    .flat(flat)
  );

  //////////////////////////////////////////////////////////////////////
  // field decode
  logic [7:0] ovf, msl, cfirst, clast, vse, ulr, vbe, mode;
  rtu_line_t vtotal, vactive_end, vsync_beg, vblank_beg, split_line;
  rtu_addr_t origin, cur_pos;
  rtu_skew_e skew;

  always_comb begin
    ovf = rg(flat, `RTU_IDX_OVERFLOW);
    msl = rg(flat, `RTU_IDX_MAX_SCAN);
    cfirst = rg(flat, `RTU_IDX_CUR_FIRST);
    clast = rg(flat, `RTU_IDX_CUR_LAST);
    vse = rg(flat, `RTU_IDX_VSYNC_END);
    ulr = rg(flat, `RTU_IDX_UNDERLINE);
    vbe = rg(flat, `RTU_IDX_VBLANK_END);
    mode = rg(flat, `RTU_IDX_MODE);
    vtotal = {ovf[`RTU_OVF_VTOTAL9], ovf[`RTU_OVF_VTOTAL8],
              rg(flat, `RTU_IDX_VTOTAL)};
    vactive_end = {ovf[`RTU_OVF_ACTEND9], ovf[`RTU_OVF_ACTEND8],
                   rg(flat, `RTU_IDX_ACTIVE_END)};
    vsync_beg = {ovf[`RTU_OVF_VSYNC9], ovf[`RTU_OVF_VSYNC8],
                 rg(flat, `RTU_IDX_VSYNC_BEGIN)};
    vblank_beg = {msl[`RTU_MSL_VBLANK9], ovf[`RTU_OVF_VBLANK8],
                  rg(flat, `RTU_IDX_VBLANK_BEG)};
    split_line = {msl[`RTU_MSL_SPLIT9], ovf[`RTU_OVF_SPLIT8],
                  rg(flat, `RTU_IDX_SPLIT_LINE)};
    origin = {rg(flat, `RTU_IDX_ORIGIN_HI),
              rg(flat, `RTU_IDX_ORIGIN_LO)};
    cur_pos = {rg(flat, `RTU_IDX_CURPOS_HI),
               rg(flat, `RTU_IDX_CURPOS_LO)};
    skew = rtu_skew_e'(clast[`RTU_CUR_SKEW_LO +: 2]);
  end

  //////////////////////////////////////////////////////////////////////
  // fetch address mapping: shift for word/doubleword, bit substitution
  function automatic rtu_addr_t map_addr(input rtu_addr_t a,
                                         input logic [7:0] md,
                                         input logic shift2,
                                         input logic [4:0] rs,
                                         input logic act);
    rtu_addr_t o;
    o = a;
    if (shift2) begin
      o = {2'b00, a[15:2]};
    end else if (!md[`RTU_MODE_BYTE]) begin
      o = {1'b0, a[15:1]};
      o[0] = md[`RTU_MODE_WRAP15] ? a[15] : a[13];
    end
    if (act && !md[`RTU_MODE_SUB13]) begin
      o[13] = rs[0];
    end
    if (act && !md[`RTU_MODE_SUB14]) begin
      o[14] = rs[1];
    end
    map_addr = o;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // vertical, row and address counters
  rtu_line_t vcnt_q, vcnt_d;
  logic [4:0] row_q, row_d;
  rtu_addr_t row_start_q, row_start_d, ma_q, ma_d;
  logic vhalf_q, vhalf_d, rhalf_q, rhalf_d;
  logic [1:0] div_q, div_d;
  logic vtick, rtick, frame_end, split_hit, adv, active;
  logic [15:0] pitch_step;

  always_comb begin
    vhalf_d = vhalf_q ^ hline_pulse;
    vtick = hline_pulse && (!mode[`RTU_MODE_VHALF] || vhalf_q);
    rhalf_d = rhalf_q ^ vtick;
    rtick = vtick && (!msl[`RTU_MSL_DOUBLE] || rhalf_q);
    frame_end = vtick && (vcnt_q == vtotal);
    vcnt_d = vcnt_q;
    if (frame_end) begin
      vcnt_d = 10'h000;
    end else if (vtick) begin
      vcnt_d = vcnt_q + 10'h001;
    end
    row_d = row_q;
    if (frame_end) begin
      row_d = 5'h00;
    end else if (rtick) begin
      row_d = (row_q == msl[4:0]) ? 5'h00 : row_q + 5'h01;
    end
    // byte mode steps by pitch*2, word mode by pitch*4
    pitch_step = mode[`RTU_MODE_BYTE] ?
      {7'h00, rg(flat, `RTU_IDX_ROW_PITCH), 1'b0} :
      {6'h00, rg(flat, `RTU_IDX_ROW_PITCH), 2'b00};
    split_hit = vtick && !frame_end && (vcnt_d == split_line);
    row_start_d = row_start_q;
    if (frame_end) begin
      row_start_d = origin;
    end else if (split_hit) begin
      row_start_d = 16'h0000;
    end else if (rtick && row_q == msl[4:0]) begin
      row_start_d = row_start_q + pitch_step;
    end
    active = hdisp_in && vdisp_out;
    div_d = active ? div_q + 2'h1 : 2'h0;
    if (ulr[`RTU_UL_COUNT4]) begin
      adv = active && div_q == 2'h3;
    end else if (mode[`RTU_MODE_COUNT2]) begin
      adv = active && div_q[0];
    end else begin
      adv = active;
    end
    ma_d = ma_q;
    if (vtick) begin
      ma_d = row_start_d;
    end else if (adv) begin
      ma_d = ma_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vcnt_q <= 10'h000;
      row_q <= 5'h00;
      row_start_q <= 16'h0000;
      ma_q <= 16'h0000;
      vhalf_q <= 1'b0;
      rhalf_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      vcnt_q <= vcnt_d;
      row_q <= row_d;
      row_start_q <= row_start_d;
      ma_q <= ma_d;
      vhalf_q <= vhalf_d;
      rhalf_q <= rhalf_d;
      div_q <= div_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timing outputs, cursor and interrupt
  logic vsync_q, vsync_d, vblank_q, vblank_d, vdisp_q, vdisp_d;
  logic hret_q, hret_d, vret_q, vret_d;
  logic cur_raw, cur_q, cur_d, ul_q, ul_d;
  logic [2:0] cdly_q, cdly_d;
  logic flag_q, flag_d, irq_q, irq_d, vint_set, vint_clr;
  logic [15:0] addr_q, addr_d;
  logic [4:0] rs_q;
  logic [2:0] ref_q, ref_d;

  always_comb begin
    vsync_d = vsync_q;
    vblank_d = vblank_q;
    if (vtick && vcnt_d == vsync_beg) begin
      vsync_d = 1'b1;
    end else if (vtick && vcnt_d[3:0] == vse[3:0]) begin
      vsync_d = 1'b0;
    end
    if (vtick && vcnt_d == vblank_beg) begin
      vblank_d = 1'b1;
    end else if (vtick && vcnt_d[7:0] == vbe) begin
      vblank_d = 1'b0;
    end
    vdisp_d = vcnt_d <= vactive_end;
    hret_d = hretrace_in && mode[`RTU_MODE_RETRACE];
    vret_d = vsync_d && mode[`RTU_MODE_RETRACE];
    // a start value above the end value suppresses the cursor
    cur_raw = active && ma_q == cur_pos && !cfirst[`RTU_CUR_OFF] &&
              cfirst[4:0] <= clast[4:0] &&
              {1'b0, row_q} >= {1'b0, cfirst[4:0]} + 6'h01 &&
              row_q <= clast[4:0];
    cdly_d = {cdly_q[1:0], cur_raw};
    case (skew)
      RTU_SKEW_0: cur_d = cur_raw;
      RTU_SKEW_1: cur_d = cdly_q[0];
      RTU_SKEW_2: cur_d = cdly_q[1];
      RTU_SKEW_3: cur_d = cdly_q[2];
      default: cur_d = cur_raw;
    endcase
    ul_d = active && {1'b0, row_q} == {1'b0, ulr[4:0]} + 6'h01;
    addr_d = map_addr(ma_q, mode, ulr[`RTU_UL_DWORD] ||
                      vbe[`RTU_VBE_SHIFT2], row_q, active);
    ref_d = vse[`RTU_VSE_FIVE_REF] ? `RTU_REFRESH_FIVE :
                                      `RTU_REFRESH_THREE;
    // set wins over a clear landing in the same cycle
    vint_set = vsync_d && !vsync_q && !vse[`RTU_VSE_DISABLE];
    vint_clr = rf_we && idx_q == `RTU_IDX_VSYNC_END &&
               !port_wdata[`RTU_VSE_CLEAR];
    flag_d = vint_set || (flag_q && !vint_clr);
    irq_d = flag_d && !vse[`RTU_VSE_DISABLE];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vsync_q <= 1'b0;
      vblank_q <= 1'b0;
      vdisp_q <= 1'b0;
      hret_q <= 1'b0;
      vret_q <= 1'b0;
      cdly_q <= 3'h0;
      cur_q <= 1'b0;
      ul_q <= 1'b0;
      addr_q <= 16'h0000;
      rs_q <= 5'h00;
      ref_q <= `RTU_REFRESH_THREE;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      vsync_q <= vsync_d;
      vblank_q <= vblank_d;
      vdisp_q <= vdisp_d;
      hret_q <= hret_d;
      vret_q <= vret_d;
      cdly_q <= cdly_d;
      cur_q <= cur_d;
      ul_q <= ul_d;
      addr_q <= addr_d;
      rs_q <= row_d;
      ref_q <= ref_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  assign hretrace_out = hret_q;
  assign vretrace_out = vret_q;
  assign vblank_out = vblank_q;
  assign vdisp_out = vdisp_q;
  assign cursor_out = cur_q;
  assign underline_out = ul_q;
  assign mem_addr = addr_q;
  assign row_scan = rs_q;
  assign refresh_cycles = ref_q;
  assign vint_pending = flag_q;
  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_row_at_max;
    rtick && row_q == msl[4:0] && !frame_end;
  endsequence
  sequence s_sel_data_wr;
    port_wr && port_sel && idx_q < 5'(NREGS);
  endsequence

  AST_ROW_WRAP: assert property (s_row_at_max |=> row_q == 5'h00)
    else $error("row scan did not wrap at max");
  AST_DOUBLE: assert property (vtick && msl[`RTU_MSL_DOUBLE] && !rhalf_q
    && !frame_end |=> $stable(row_q))
    else $error("row scan advanced on skipped line");
  AST_CURSOR_OFF: assert property (cfirst[`RTU_CUR_OFF] ||
    cfirst[4:0] > clast[4:0] |-> !cur_raw)
    else $error("cursor shown while disabled");
  AST_FRAME_ORIGIN: assert property (frame_end |=> ma_q == $past(origin))
    else $error("frame start did not load origin");
  AST_PROTECT: assert property (s_sel_data_wr ##0 (prot && idx_q <
    `RTU_IDX_LAST_PROT) |=> $stable(flat))
    else $error("protected register changed");
  AST_SPLIT: assert property (split_hit |=> ma_q == 16'h0000)
    else $error("split line did not clear address");
  AST_VINT_SET: assert property (vint_set |=> vint_pending ##1
    (vint_pending || $past(vint_clr)))
    else $error("retrace event lost");
  AST_RETRACE_GATE: assert property (!mode[`RTU_MODE_RETRACE] ##1
    !mode[`RTU_MODE_RETRACE] |-> !vretrace_out && !hretrace_out)
    else $error("retrace driven while forced off");
  AST_REFRESH: assert property (##1 refresh_cycles == ($past(
    vse[`RTU_VSE_FIVE_REF]) ? `RTU_REFRESH_FIVE : `RTU_REFRESH_THREE))
    else $error("refresh count wrong");
  AST_RESERVED: assert property (s_sel_data_wr ##0 idx_q ==
    `RTU_IDX_MODE |=> !mode[4])
    else $error("reserved mode bit written");
endmodule

// >>> testbench/rtu_hsection.sv
// rtu_hsection.sv: stand-in for the horizontal section feeding the
// raster timing unit: line pulse, retrace level and display window.
// assumes: fixed lines of LINE character clocks, changes at falling edge.
`timescale 1ns/1ps
module rtu_hsection #(
  parameter int LINE = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // horizontal timing out
  output logic hline_pulse,
  output logic hretrace_in,
  output logic hdisp_in
);
  int pos;

  // character position; silent in reset so no line reaches the unit
  always @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos <= 0;
      hline_pulse <= 1'b0;
      hretrace_in <= 1'b0;
      hdisp_in <= 1'b0;
    end else begin
      pos <= (pos == LINE - 1) ? 0 : pos + 1;
      // pulses stay LINE clocks apart, well over the two-cycle minimum
      hline_pulse <= (pos == LINE - 1);
      hdisp_in <= (pos < 4);
      hretrace_in <= (pos == 5) || (pos == 6);
    end
  end
endmodule

// >>> testbench/tb.sv
// tb.sv: self-checking bench for rtu_timing through its index/data port.
// assumes: rtu_hsection gives eight-clock lines; clk is 20 MHz.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic port_wr = 1'b0;
  logic port_sel = 1'b0;
  logic [7:0] port_wdata = 8'h00;
  logic [7:0] port_rdata, rv;
  logic hline_pulse, hretrace_in, hdisp_in;
  logic hretrace_out, vretrace_out, vblank_out, vdisp_out;
  logic cursor_out, underline_out, vint_pending, irq;
  logic [15:0] mem_addr;
  logic [4:0] row_scan;
  logic [2:0] refresh_cycles;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int mx1, ch1, mx2, ch2, hs, vs;
  logic [4:0] ix [6] = '{5'h09, 5'h0A, 5'h0B, 5'h14, 5'h17, 5'h1C};
  logic [7:0] ex [6] = '{8'hFF, 8'h3F, 8'h7F, 8'h7F, 8'hEF, 8'h00};

  //////////////////////////////////////////////////////////////////////////////
  rtu_hsection u_rtu_hsection (.clk(clk), .reset_n(reset_n),
    .hline_pulse(hline_pulse), .hretrace_in(hretrace_in),
    .hdisp_in(hdisp_in));
  rtu_timing u_rtu_timing (.clk(clk), .reset_n(reset_n),
    .port_wr(port_wr), .port_sel(port_sel), .port_wdata(port_wdata),
    .port_rdata(port_rdata), .hline_pulse(hline_pulse),
    .hretrace_in(hretrace_in), .hdisp_in(hdisp_in),
    .hretrace_out(hretrace_out), .vretrace_out(vretrace_out),
    .vblank_out(vblank_out), .vdisp_out(vdisp_out),
    .cursor_out(cursor_out), .underline_out(underline_out),
    .mem_addr(mem_addr), .row_scan(row_scan),
    .refresh_cycles(refresh_cycles), .vint_pending(vint_pending),
    .irq(irq));

  // clock and hang guard; a frame is 160 cycles, the 20000-cycle guard is far above the test run
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // index write, then data write on the next cycle
  task automatic wr(input logic [4:0] idx, input logic [7:0] val);
    @(negedge clk);
    port_wr = 1'b1;
    port_sel = 1'b0;
    port_wdata = {3'h0, idx};
    @(negedge clk);
    port_sel = 1'b1;
    port_wdata = val;
    @(negedge clk);
    port_wr = 1'b0;
  endtask

  // data port answers two cycles after the index settles
  task automatic rd(input logic [4:0] idx, output logic [7:0] val);
    @(negedge clk);
    port_wr = 1'b1;
    port_sel = 1'b0;
    port_wdata = {3'h0, idx};
    @(negedge clk);
    port_wr = 1'b0;
    port_sel = 1'b1;
    repeat (3) @(negedge clk);
    val = port_rdata;
  endtask

  // largest row count, row changes and retrace activity over n cycles
  task automatic watch(input int n, output int mx, output int ch,
                       output int h, output int v);
    logic [4:0] last;
    mx = 0;
    ch = 0;
    h = 0;
    v = 0;
    last = row_scan;
    repeat (n) begin
      @(negedge clk);
      if (row_scan > mx) mx = row_scan;
      if (row_scan != last) ch++;
      last = row_scan;
      if (hretrace_out === 1'b1) h = 1;
      if (vretrace_out === 1'b1) v = 1;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk_byte("refresh", 8'h03, {5'h0, refresh_cycles});
    // reset value, then reserved bits and unmapped index read zero
    for (int i = 0; i < 6; i++) begin
      rd(ix[i], rv);
      chk_byte("reset value", 8'h00, rv);
      wr(ix[i], 8'hFF);
      rd(ix[i], rv);
      chk_byte("masked readback", ex[i], rv);
    end
    // protected registers ignore writes except the split bit
    wr(5'h11, 8'h90);
    wr(5'h06, 8'h55);
    rd(5'h06, rv);
    chk_byte("protected total", 8'h00, rv);
    wr(5'h07, 8'hFF);
    rd(5'h07, rv);
    chk_byte("protected overflow", 8'h10, rv);
    // refresh output is a flop behind the register: one more edge
    wr(5'h11, 8'h50);
    @(negedge clk);
    chk_byte("refresh", 8'h05, {5'h0, refresh_cycles});
    wr(5'h11, 8'h37);
    @(negedge clk);
    chk_byte("refresh", 8'h03, {5'h0, refresh_cycles});
    // 20-line frame, three-line rows, retrace on lines 5 and 6
    wr(5'h07, 8'h00);
    wr(5'h06, 8'h13);
    wr(5'h09, 8'h02);
    wr(5'h10, 8'h05);
    wr(5'h12, 8'h0F);
    wr(5'h17, 8'h40);
    watch(320, mx1, ch1, hs, vs);
    chk_bit("hretrace gated", 1'b0, hs != 0);
    chk_bit("vretrace gated", 1'b0, vs != 0);
    chk_byte("row max", 8'h02, mx1[7:0]);
    wr(5'h09, 8'h82);
    watch(320, mx2, ch2, hs, vs);
    chk_byte("row max doubled", 8'h02, mx2[7:0]);
    chk_bit("row rate halved", 1'b1,
            (ch2 * 2 <= ch1 + 4) && (ch2 * 2 >= ch1 - 4));
    // retrace enabled, interrupt cleared and armed
    wr(5'h09, 8'h02);
    wr(5'h17, 8'hC0);
    wr(5'h11, 8'h07);
    for (int i = 0; i < 400 && vint_pending !== 1'b1; i++)
      @(negedge clk);
    chk_bit("pending", 1'b1, vint_pending);
    chk_bit("irq", 1'b1, irq);
    chk_bit("vretrace", 1'b1, vretrace_out);
    wr(5'h11, 8'h37);
    @(negedge clk);
    chk_bit("pending kept", 1'b1, vint_pending);
    chk_bit("irq disabled", 1'b0, irq);
    wr(5'h11, 8'h27);
    @(negedge clk);
    chk_bit("pending cleared", 1'b0, vint_pending);
    watch(320, mx1, ch1, hs, vs);
    chk_bit("hretrace passes", 1'b1, hs != 0);
    close_out();
  end
endmodule
